// [mhcrb_pkg.sv]
// Constants shared by the miscellaneous host configuration register bank
`default_nettype none
package mhcrb_pkg;

	// ------------------------------------------------------------
	// Register offsets on the host port
	// ------------------------------------------------------------
	localparam int           ADDR_W          = 5;
	localparam int           DATA_W          = 16;
	localparam logic [4:0]   OFS_MISC        = 5'h0D;
	localparam logic [4:0]   OFS_TMR_LO      = 5'h0E;
	localparam logic [4:0]   OFS_TMR_HI      = 5'h0F;
	localparam logic [4:0]   OFS_DATA_PORT   = 5'h10;
	localparam logic [4:0]   OFS_GAP_ONE     = 5'h12;
	localparam logic [4:0]   OFS_GAP_TWO     = 5'h13;
	localparam logic [4:0]   OFS_MGMT        = 5'h14;
	localparam logic [4:0]   OFS_BUF_CFG     = 5'h15;
	localparam logic [4:0]   OFS_B2B_GAP     = 5'h16;

	// ------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [7:0]   RST_MISC        = 8'h00;
	localparam logic [7:0]   RST_TMR_BYTE    = 8'hFF;
	localparam logic [7:0]   RST_GAP_ONE     = 8'h0C;
	localparam logic [7:0]   RST_GAP_TWO     = 8'h12;
	localparam logic [7:0]   RST_MGMT        = 8'h00;
	localparam logic [7:0]   RST_BUF_CFG     = 8'h00;
	localparam logic [7:0]   RST_B2B_GAP     = 8'h15;
	localparam logic [15:0]  RST_WORD        = 16'h0000;
	localparam logic [7:0]   MSK_MISC        = 8'h07;
	localparam logic [7:0]   MSK_GAP         = 8'h7F;
	localparam logic [7:0]   MSK_MGMT        = 8'hBB;
	localparam logic [7:0]   MSK_BUF_CFG     = 8'h77;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int           B_TMR_EN        = 2;
	localparam int           B_BURST_SEL     = 1;
	localparam int           B_TX_RING       = 0;
	localparam int           B_EE_CLK        = 7;
	localparam int           B_EE_SAMPLE     = 6;
	localparam int           B_EE_DRIVE      = 5;
	localparam int           B_EE_SEL        = 4;
	localparam int           B_MD_DRIVE      = 3;
	localparam int           B_MD_SAMPLE     = 2;
	localparam int           B_DIR_IN        = 1;
	localparam int           B_MDC           = 0;
	localparam int           B_WAKE_IRQ_EN   = 6;
	localparam int           B_IRQ_PP        = 5;
	localparam int           B_IRQ_POLARITY       = 4;
	localparam int           B_WAKE_PULSE    = 2;
	localparam int           B_WAKE_PP       = 1;
	localparam int           B_WAKE_POL      = 0;

	// ------------------------------------------------------------
	// Ring, gap and timing constants
	// ------------------------------------------------------------
	localparam logic [7:0]   TX_RING_FIRST   = 8'h40;
	localparam logic [15:0]  DMA_STEP        = 16'h0002;
	localparam logic [9:0]   GAP_BIT_BIAS    = 10'h00C;
	localparam int           CLK_PERIOD_NS   = 40;
	localparam int           WAKE_PULSE_MS   = 60;
	localparam int           WAKE_PULSE_CYC  =
		(WAKE_PULSE_MS * 1000000) / CLK_PERIOD_NS;

	// Wake indication sequencer
	typedef enum logic [1:0] {
		WK_IDLE  = 2'b00,
		WK_PULSE = 2'b01,
		WK_HOLD  = 2'b10
	} mhcrb_wake_e;

endpackage
`default_nettype wire

// [mhcrb_regs.sv]
// Miscellaneous host configuration register bank with pin control
`default_nettype none

module mhcrb_regs #(
	parameter int WAKE_CYC = mhcrb_pkg::WAKE_PULSE_CYC
) (
	// Clock, reset and freeze
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic                          ce,
	// Host port, active-low strobes
	input  wire logic                          host_cs_b,
	input  wire logic                          host_rd_b,
	input  wire logic                          host_wr_b,
	input  wire logic [mhcrb_pkg::ADDR_W-1:0]  host_addr,
	input  wire logic [mhcrb_pkg::DATA_W-1:0]  host_wdata,
	output var  logic [mhcrb_pkg::DATA_W-1:0]  host_rdata,
	// Burst stepping line
	output var  logic                          burst_addr_line,
	// Packet memory through the data port
	input  wire logic                          dma_load,
	input  wire logic [15:0]                   dma_load_addr,
	input  wire logic [7:0]                    rx_ring_start_page,
	input  wire logic [15:0]                   dp_rd_data,
	output var  logic [15:0]                   dma_addr,
	output var  logic [15:0]                   dp_wr_data,
	output var  logic                          dp_wr_stb,
	output var  logic                          dp_rd_stb,
	// General-purpose timer
	output var  logic                          gp_timer_expire,
	// MAC gap settings
	output var  logic [6:0]                    gap_segment_one,
	output var  logic [6:0]                    gap_segment_two,
	output var  logic [6:0]                    back_to_back_gap_code,
	output var  logic [9:0]                    back_to_back_gap_bits,
	// EEPROM pins
	output var  logic                          eeprom_clk,
	output var  logic                          eeprom_cs,
	input  wire logic                          eeprom_data_in,
	output var  logic                          eeprom_data_out,
	output var  logic                          eeprom_data_oe,
	// PHY management
	output var  logic                          mdc,
	input  wire logic                          mdio_in,
	output var  logic                          mdio_out,
	output var  logic                          mdio_oe,
	// Interrupt and wake event sources and pins
	input  wire logic                          irq_req,
	input  wire logic                          wake_event,
	input  wire logic                          wake_clear,
	output var  logic                          irq_out,
	output var  logic                          irq_oe,
	output var  logic                          wake_out,
	output var  logic                          wake_oe
);
	import mhcrb_pkg::*;

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0]  misc_control_ff;
	logic [7:0]  gp_timer_low_byte_ff;
	logic [7:0]  gp_timer_high_byte_ff;
	logic [7:0]  gap_segment_one_ff;
	logic [7:0]  gap_segment_two_ff;
	logic [7:0]  serial_mgmt_bitbang_reg_ff;
	logic [7:0]  output_buffer_config_reg_ff;
	logic [7:0]  back_to_back_gap_ff;
	logic        wr_seen_ff;
	logic        rd_seen_ff;
	logic        wr_take;
	logic        rd_take;
	logic        rd_act;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;

	// Offset decode, shared by write and read paths
	function automatic logic hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs
	);
		hit = (a == ofs);
	endfunction

	// Masked byte write: reserved bits stay zero
	function automatic logic [7:0] wbyte(
		input logic [7:0] d,
		input logic [7:0] m
	);
		wbyte = d & m;
	endfunction

	// ------------------------------------------------------------
	// Host strobe handling
	// ------------------------------------------------------------
	// A long strobe counts once, so the data port moves one word
	assign rd_act  = ~host_cs_b & ~host_rd_b;
	assign wr_take = ~host_cs_b & ~host_wr_b & ~wr_seen_ff;
	assign rd_take = rd_act & ~rd_seen_ff;

	// Strobe history
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_seen_ff <= 1'b0;
			rd_seen_ff <= 1'b0;
		end else if (ce) begin
			wr_seen_ff <= ~host_cs_b & ~host_wr_b;
			rd_seen_ff <= rd_act;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Configuration bytes, low lane of the write data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			misc_control_ff             <= RST_MISC;
			gp_timer_low_byte_ff        <= RST_TMR_BYTE;
			gp_timer_high_byte_ff       <= RST_TMR_BYTE;
			gap_segment_one_ff          <= RST_GAP_ONE;
			gap_segment_two_ff          <= RST_GAP_TWO;
			serial_mgmt_bitbang_reg_ff  <= RST_MGMT;
			output_buffer_config_reg_ff <= RST_BUF_CFG;
			back_to_back_gap_ff         <= RST_B2B_GAP;
		end else if (ce && wr_take) begin
			if (hit(host_addr, OFS_MISC)) begin
				misc_control_ff <= wbyte(host_wdata[7:0], MSK_MISC);
			end
			if (hit(host_addr, OFS_TMR_LO)) begin
				gp_timer_low_byte_ff <= host_wdata[7:0];
			end
			if (hit(host_addr, OFS_TMR_HI)) begin
				gp_timer_high_byte_ff <= host_wdata[7:0];
			end
			if (hit(host_addr, OFS_GAP_ONE)) begin
				gap_segment_one_ff <= wbyte(host_wdata[7:0], MSK_GAP);
			end
			if (hit(host_addr, OFS_GAP_TWO)) begin
				gap_segment_two_ff <= wbyte(host_wdata[7:0], MSK_GAP);
			end
			if (hit(host_addr, OFS_MGMT)) begin
				// Sample bits are not stored, they come from the pins
				serial_mgmt_bitbang_reg_ff <= wbyte(host_wdata[7:0], MSK_MGMT);
			end
			if (hit(host_addr, OFS_BUF_CFG)) begin
				output_buffer_config_reg_ff <=
					wbyte(host_wdata[7:0], MSK_BUF_CFG);
			end
			if (hit(host_addr, OFS_B2B_GAP)) begin
				back_to_back_gap_ff <= wbyte(host_wdata[7:0], MSK_GAP);
			end
		end
	end

	// ------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------
	// Read mux; unmapped offsets answer zero
	always_comb begin
		nxt_rdata = RST_WORD;
		if (hit(host_addr, OFS_MISC)) begin
			nxt_rdata[7:0] = misc_control_ff;
		end else if (hit(host_addr, OFS_TMR_LO)) begin
			nxt_rdata[7:0] = gp_timer_low_byte_ff;
		end else if (hit(host_addr, OFS_TMR_HI)) begin
			nxt_rdata[7:0] = gp_timer_high_byte_ff;
		end else if (hit(host_addr, OFS_DATA_PORT)) begin
			nxt_rdata = dp_rd_data;
		end else if (hit(host_addr, OFS_GAP_ONE)) begin
			nxt_rdata[7:0] = gap_segment_one_ff;
		end else if (hit(host_addr, OFS_GAP_TWO)) begin
			nxt_rdata[7:0] = gap_segment_two_ff;
		end else if (hit(host_addr, OFS_MGMT)) begin
			nxt_rdata[7:0] = serial_mgmt_bitbang_reg_ff;
			nxt_rdata[B_EE_SAMPLE] = eeprom_data_in;
			nxt_rdata[B_MD_SAMPLE] = mdio_in;
		end else if (hit(host_addr, OFS_BUF_CFG)) begin
			nxt_rdata[7:0] = output_buffer_config_reg_ff;
		end else if (hit(host_addr, OFS_B2B_GAP)) begin
			nxt_rdata[7:0] = back_to_back_gap_ff;
		end
	end

	// Read data follows the address while the read strobe is low
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= RST_WORD;
		end else if (ce && rd_act) begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign host_rdata = rdata_ff;

	// ------------------------------------------------------------
	// Burst address base
	// ------------------------------------------------------------
	logic burst_line_ff;

	// Chosen host address line for burst stepping
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			burst_line_ff <= 1'b0;
		end else if (ce) begin
			burst_line_ff <= misc_control_ff[B_BURST_SEL] ?
				host_addr[1] : host_addr[0];
		end
	end
	assign burst_addr_line = burst_line_ff;

	// ------------------------------------------------------------
	// Data port and remote DMA address
	// ------------------------------------------------------------
	logic [15:0] dma_addr_ff;
	logic [15:0] nxt_dma_addr;
	logic [15:0] dp_wr_data_ff;
	logic        dp_wr_stb_ff;
	logic        dp_rd_stb_ff;
	logic        dp_wr_hit;
	logic        dp_rd_hit;

	assign dp_wr_hit = wr_take & hit(host_addr, OFS_DATA_PORT);
	assign dp_rd_hit = rd_take & hit(host_addr, OFS_DATA_PORT);

	// Next word address; only writes wrap, reads roll over freely
	always_comb begin
		nxt_dma_addr = dma_addr_ff + DMA_STEP;
		if (dp_wr_hit && misc_control_ff[B_TX_RING] &&
		    nxt_dma_addr[15:8] == rx_ring_start_page) begin
			nxt_dma_addr = {TX_RING_FIRST, 8'h00};
		end
	end

	// Pointer; with the ring off it steps through all memory
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dma_addr_ff <= RST_WORD;
		end else if (ce) begin
			if (dma_load) begin
				dma_addr_ff <= dma_load_addr;
			end else if (dp_wr_hit || dp_rd_hit) begin
				dma_addr_ff <= nxt_dma_addr;
			end
		end
	end

	// Word strobes toward the packet memory
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_wr_data_ff <= RST_WORD;
			dp_wr_stb_ff  <= 1'b0;
			dp_rd_stb_ff  <= 1'b0;
		end else if (ce) begin
			dp_wr_stb_ff <= dp_wr_hit;
			dp_rd_stb_ff <= dp_rd_hit;
			if (dp_wr_hit) begin
				dp_wr_data_ff <= host_wdata;
			end
		end
	end
	assign dma_addr   = dma_addr_ff;
	assign dp_wr_data = dp_wr_data_ff;
	assign dp_wr_stb  = dp_wr_stb_ff;
	assign dp_rd_stb  = dp_rd_stb_ff;

	// ------------------------------------------------------------
	// General-purpose timer
	// ------------------------------------------------------------
	logic [15:0] tmr_cnt_ff;
	logic        tmr_exp_ff;
	logic [15:0] tmr_reload;

	assign tmr_reload = {gp_timer_high_byte_ff, gp_timer_low_byte_ff};

	// Down counter; a new reload takes effect at the next wrap
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tmr_cnt_ff <= {RST_TMR_BYTE, RST_TMR_BYTE};
			tmr_exp_ff <= 1'b0;
		end else if (ce) begin
			tmr_exp_ff <= 1'b0;
			if (!misc_control_ff[B_TMR_EN]) begin
				tmr_cnt_ff <= tmr_reload;
			end else if (tmr_cnt_ff == RST_WORD) begin
				tmr_cnt_ff <= tmr_reload;
				tmr_exp_ff <= 1'b1;
			end else begin
				tmr_cnt_ff <= tmr_cnt_ff - 16'h0001;
			end
		end
	end
	assign gp_timer_expire = tmr_exp_ff;

	// ------------------------------------------------------------
	// Gap settings toward the MAC
	// ------------------------------------------------------------
	logic [9:0] gap_bits_ff;

	// Bit times are four per code step plus a fixed bias
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_bits_ff <= 10'h060;
		end else if (ce) begin
			gap_bits_ff <= {1'b0, back_to_back_gap_ff[6:0], 2'b00}
				+ GAP_BIT_BIAS;
		end
	end
	assign gap_segment_one       = gap_segment_one_ff[6:0];
	assign gap_segment_two       = gap_segment_two_ff[6:0];
	assign back_to_back_gap_code = back_to_back_gap_ff[6:0];
	assign back_to_back_gap_bits = gap_bits_ff;

	// ------------------------------------------------------------
	// Bit-banged EEPROM and management pins
	// ------------------------------------------------------------
	// Pins follow the stored bits directly, no extra delay
	assign eeprom_clk      = serial_mgmt_bitbang_reg_ff[B_EE_CLK];
	assign eeprom_cs       = serial_mgmt_bitbang_reg_ff[B_EE_SEL];
	assign eeprom_data_out = serial_mgmt_bitbang_reg_ff[B_EE_DRIVE];
	assign mdio_out        = serial_mgmt_bitbang_reg_ff[B_MD_DRIVE];
	assign mdc             = serial_mgmt_bitbang_reg_ff[B_MDC];
	// One direction bit serves both data lines
	assign eeprom_data_oe  = ~serial_mgmt_bitbang_reg_ff[B_DIR_IN];
	assign mdio_oe         = ~serial_mgmt_bitbang_reg_ff[B_DIR_IN];

	// ------------------------------------------------------------
	// Wake indication
	// ------------------------------------------------------------
	mhcrb_wake_e  wake_st_ff;
	logic [20:0]  wake_cnt_ff;
	logic         wake_act;
	localparam logic [20:0] WAKE_LAST = 21'(WAKE_CYC - 1);

	// Static mode holds until cleared; a new event beats the clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_st_ff  <= WK_IDLE;
			wake_cnt_ff <= '0;
		end else if (ce) begin
			case (wake_st_ff)
				WK_IDLE: begin
					wake_cnt_ff <= '0;
					if (wake_event) begin
						wake_st_ff <= output_buffer_config_reg_ff[B_WAKE_PULSE] ?
							WK_PULSE : WK_HOLD;
					end
				end
				WK_PULSE: begin
					wake_cnt_ff <= wake_cnt_ff + 21'h000001;
					if (wake_cnt_ff == WAKE_LAST) begin
						wake_st_ff <= WK_IDLE;
					end
				end
				WK_HOLD: begin
					if (wake_clear && !wake_event) begin
						wake_st_ff <= WK_IDLE;
					end
				end
				default: begin
					wake_st_ff <= WK_IDLE;
				end
			endcase
		end
	end
	assign wake_act = (wake_st_ff != WK_IDLE);

	// ------------------------------------------------------------
	// Output buffer drive
	// ------------------------------------------------------------
	logic irq_out_ff;
	logic irq_oe_ff;
	logic wake_out_ff;
	logic wake_oe_ff;
	logic irq_act;

	// Wake joins the interrupt only when enabled
	assign irq_act = irq_req |
		(output_buffer_config_reg_ff[B_WAKE_IRQ_EN] & wake_act);

	// Open-drain pulls low when active; push-pull honours polarity
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_out_ff  <= 1'b0;
			irq_oe_ff   <= 1'b0;
			wake_out_ff <= 1'b0;
			wake_oe_ff  <= 1'b0;
		end else if (ce) begin
			if (output_buffer_config_reg_ff[B_IRQ_PP]) begin
				irq_oe_ff  <= 1'b1;
				irq_out_ff <= irq_act ~^
					output_buffer_config_reg_ff[B_IRQ_POLARITY];
			end else begin
				irq_oe_ff  <= irq_act;
				irq_out_ff <= 1'b0;
			end
			if (output_buffer_config_reg_ff[B_WAKE_PP]) begin
				wake_oe_ff  <= 1'b1;
				wake_out_ff <= wake_act ~^
					output_buffer_config_reg_ff[B_WAKE_POL];
			end else begin
				wake_oe_ff  <= wake_act;
				wake_out_ff <= 1'b0;
			end
		end
	end
	assign irq_out  = irq_out_ff;
	assign irq_oe   = irq_oe_ff;
	assign wake_out = wake_out_ff;
	assign wake_oe  = wake_oe_ff;

endmodule
`default_nettype wire

// [mhcrb_properties.sv]
// Port-level assertions for the register bank
`default_nettype none
module mhcrb_properties (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        ce,
	// Host port
	input wire logic        host_cs_b,
	input wire logic        host_rd_b,
	input wire logic        host_wr_b,
	input wire logic [4:0]  host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic [15:0] host_rdata,
	// Watched outputs and pin levels
	input wire logic        burst_addr_line,
	input wire logic        dp_wr_stb,
	input wire logic [15:0] dp_wr_data,
	input wire logic        gp_timer_expire,
	input wire logic [6:0]  back_to_back_gap_code,
	input wire logic [9:0]  back_to_back_gap_bits,
	input wire logic        eeprom_clk,
	input wire logic        eeprom_cs,
	input wire logic        eeprom_data_in,
	input wire logic        eeprom_data_out,
	input wire logic        eeprom_data_oe,
	input wire logic        mdc,
	input wire logic        mdio_in,
	input wire logic        mdio_out,
	input wire logic        mdio_oe,
	input wire logic        irq_out,
	input wire logic        wake_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import mhcrb_pkg::*;

	// ----------------------------------------
	// Accepted accesses and mirrored bits
	// ----------------------------------------
	logic        prev_ff;
	logic        en_ff;
	logic        sel_ff;
	logic        ipp_ff;
	logic        wpp_ff;
	logic [15:0] wd_ff;
	logic        wr_go;
	logic        rd_go;
	logic        pick;
	assign wr_go = ce & ~host_cs_b & ~host_wr_b & ~prev_ff;
	assign rd_go = ce & ~host_cs_b & ~host_rd_b;
	assign pick  = sel_ff ? host_addr[1] : host_addr[0];

	// Mirrors follow accepted writes; held strobe counts once
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{prev_ff, en_ff, sel_ff, ipp_ff, wpp_ff} <= 5'h00;
			wd_ff <= 16'h0000;
		end else begin
			prev_ff <= ~host_cs_b & ~host_wr_b;
			wd_ff <= host_wdata;
			if (wr_go && host_addr == OFS_MISC) {en_ff, sel_ff} <= host_wdata[2:1];
			if (wr_go && host_addr == OFS_BUF_CFG) {ipp_ff, wpp_ff} <= {host_wdata[5], host_wdata[1]};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence mg_wr;
		wr_go && host_addr == OFS_MGMT;
	endsequence
	sequence code_held;
		$stable(back_to_back_gap_code) ##1 $stable(back_to_back_gap_code);
	endsequence

	mgmt_pins_a: assert property (mg_wr |=>
		{eeprom_clk, eeprom_cs, eeprom_data_out, mdio_out, mdc} ==
		{wd_ff[7], wd_ff[4], wd_ff[5], wd_ff[3], wd_ff[0]}) else $error("management pins wrong");
	dir_oe_a: assert property (mg_wr |=>
		eeprom_data_oe == !wd_ff[1] && mdio_oe == !wd_ff[1]) else $error("pin direction wrong");
	pin_read_a: assert property (rd_go && host_addr == OFS_MGMT |=>
		host_rdata[6] == $past(eeprom_data_in) && host_rdata[2] == $past(mdio_in))
		else $error("pin sample wrong");
	misc_resv_a: assert property (rd_go && host_addr == OFS_MISC |=>
		host_rdata[15:3] == 13'h0000) else $error("reserved bits set");
	gap_bits_a: assert property (code_held |->
		back_to_back_gap_bits == {1'b0, back_to_back_gap_code, 2'b00} + GAP_BIT_BIAS)
		else $error("gap bit time wrong");
	dp_write_a: assert property (wr_go && host_addr == OFS_DATA_PORT |=>
		dp_wr_stb && dp_wr_data == wd_ff) else $error("data port write lost");
	tmr_off_a: assert property (!en_ff [*3] |-> !gp_timer_expire)
		else $error("timer runs while disabled");
	burst_line_a: assert property ($past(rst_b) |-> burst_addr_line == $past(pick))
		else $error("burst line wrong");
	irq_od_a: assert property (!ipp_ff [*3] |-> !irq_out)
		else $error("open-drain irq driven high");
	wake_od_a: assert property (!wpp_ff [*3] |-> !wake_out)
		else $error("open-drain wake driven high");
endmodule

bind mhcrb_regs mhcrb_properties mhcrb_properties_i (.*);
`default_nettype wire

// [mhcrb_pin_model.sv]
// Far side of the pins: released data lines and packet memory
`default_nettype none
module mhcrb_pin_model (
	// Shared data lines
	input  wire logic        ee_out,
	input  wire logic        ee_oe,
	input  wire logic        md_out,
	input  wire logic        md_oe,
	input  wire logic        ee_ext,
	input  wire logic        md_ext,
	output logic             ee_pin,
	output logic             md_pin,
	// Packet memory
	input  wire logic [15:0] addr,
	output logic      [15:0] rd_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Released lines show the external level
	assign ee_pin = ee_oe ? ee_out : ee_ext;
	assign md_pin = md_oe ? md_out : md_ext;
	// Word tied to address: stale pointer shows
	assign rd_word = addr ^ 16'h5A3C;
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the register bank
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mhcrb_pkg::*;
	localparam int WC = 20;
	logic        clk, rst_b, ce, host_cs_b, host_rd_b, host_wr_b, dma_load, irq_req;
	logic        wake_event, wake_clear, ee_ext, md_ext, burst_addr_line, dp_wr_stb;
	logic        dp_rd_stb, gp_timer_expire, eeprom_clk, eeprom_cs, eeprom_data_in;
	logic        eeprom_data_out, eeprom_data_oe, mdc, mdio_in, mdio_out, mdio_oe;
	logic        irq_out, irq_oe, wake_out, wake_oe;
	logic [4:0]  host_addr;
	logic [15:0] host_wdata, host_rdata, dma_load_addr, dp_rd_data, dma_addr, dp_wr_data;
	logic [7:0]  rx_ring_start_page;
	logic [6:0]  gap_segment_one, gap_segment_two, back_to_back_gap_code;
	logic [9:0]  back_to_back_gap_bits;
	int          n_errors, samples_checked, cyc, tq[$];
	logic [15:0] wq[$];
	logic [7:0]  rm[32], mk[32];
	logic [4:0]  ofs[8] = '{5'h0D, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};
	logic [7:0]  rv[8] = '{8'h00, 8'hFF, 8'hFF, 8'h0C, 8'h12, 8'h00, 8'h00, 8'h15};
	logic [7:0]  mv[8] = '{8'h07, 8'hFF, 8'hFF, 8'h7F, 8'h7F, 8'hBB, 8'h77, 8'h7F};
	logic [7:0]  cfg[8] = '{8'h00, 8'h30, 8'h23, 8'h63, 8'h47, 8'h66, 8'h74, 8'h21};

	mhcrb_regs #(.WAKE_CYC(WC)) mhcrb_regs_i (.*);
	mhcrb_pin_model mhcrb_pin_model_i (.ee_out(eeprom_data_out), .ee_oe(eeprom_data_oe),
		.md_out(mdio_out), .md_oe(mdio_oe), .ee_ext, .md_ext, .ee_pin(eeprom_data_in),
		.md_pin(mdio_in), .addr(dma_addr), .rd_word(dp_rd_data));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Strobe capture and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dp_wr_stb) wq.push_back(dp_wr_data);
		if (gp_timer_expire) tq.push_back(cyc);
		if (cyc == 12000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bus cycles: strobes rise again before the next take
	task automatic wr(logic [4:0] a, logic [15:0] d);
		@(negedge clk);
		{host_cs_b, host_wr_b, host_addr, host_wdata} = {2'b00, a, d};
		@(negedge clk);
		{host_cs_b, host_wr_b} = 2'b11;
	endtask

	task automatic rd(logic [4:0] a, output logic [15:0] d);
		@(negedge clk);
		{host_cs_b, host_rd_b, host_addr} = {2'b00, a};
		@(negedge clk);
		{host_cs_b, host_rd_b} = 2'b11;
		d = host_rdata;
	endtask

	// Reference register file
	function automatic logic [15:0] ex(int a);
		logic [7:0] r;
		r = rm[a] & mk[a];
		if (a == 20) begin
			r[6] = rm[a][1] ? ee_ext : rm[a][5];
			r[2] = rm[a][1] ? md_ext : rm[a][3];
		end
		return {8'h00, r};
	endfunction

	function automatic logic [1:0] pin(logic act, logic pp, logic pol);
		return pp ? {1'b1, act ~^ pol} : {act, 1'b0};
	endfunction

	task automatic rinit();
		rm = '{default: 8'h00};
		mk = '{default: 8'h00};
		foreach (ofs[i]) begin
			rm[ofs[i]] = rv[i];
			mk[ofs[i]] = mv[i];
		end
	endtask

	task automatic chkall();
		logic [15:0] v;
		for (int a = 0; a < 32; a++) begin
			if (a != 16) begin
				rd(5'(a), v);
				chk("register", ex(a), v);
			end
		end
		$display("register sweep done");
	endtask

	initial begin
		logic [15:0] v, d, p;
		logic [7:0]  c;
		int          n;
		{ce, host_cs_b, host_rd_b, host_wr_b, ee_ext, md_ext} = 6'h3F;
		{rst_b, dma_load, irq_req, wake_event, wake_clear} = 5'h00;
		{host_addr, host_wdata, dma_load_addr} = 37'h0;
		rx_ring_start_page = 8'h41;
		{n_errors, samples_checked, cyc} = 96'h0;
		v = 16'($urandom(32'h90A3));
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		rinit();
		chkall();
		// Random writes, read back, pins
		for (int r = 0; r < 6; r++) begin
			{ee_ext, md_ext} = 2'($urandom);
			for (int a = 0; a < 32; a++) begin
				d = 16'($urandom);
				if (a != 16) begin
					wr(5'(a), d);
					rm[a] = d[7:0];
				end
			end
			chkall();
			c = rm[OFS_MGMT];
			chk("mgmt pins", 16'({c[7], c[4], c[5], c[3], c[0], {2{!c[1]}}}),
				16'({eeprom_clk, eeprom_cs, eeprom_data_out, mdio_out, mdc, eeprom_data_oe,
				mdio_oe}));
			chk("gap fields", {2'b00, rm[OFS_GAP_ONE][6:0], rm[OFS_GAP_TWO][6:0]},
				{2'b00, gap_segment_one, gap_segment_two});
			chk("gap bits", 16'(rm[OFS_B2B_GAP][6:0]) * 16'h0004 + 16'h000C,
				16'(back_to_back_gap_bits));
			for (int b = 1; b < 3; b++) begin
				host_addr = 5'(b);
				repeat (2) @(negedge clk);
				chk("burst line", 16'(rm[OFS_MISC][1] ? b[1] : b[0]), 16'(burst_addr_line));
			end
		end
		// Mid-run reset restores defaults
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		rinit();
		chkall();
		// Data port with and without the transmit ring
		for (int m = 0; m < 2; m++) begin
			wr(OFS_MISC, 16'(1 - m));
			@(negedge clk);
			{dma_load, dma_load_addr} = {1'b1, 16'h40FC};
			@(negedge clk);
			dma_load = 1'b0;
			p = 16'h40FC;
			for (int k = 0; k < 4; k++) begin
				d = 16'($urandom);
				wr(OFS_DATA_PORT, d);
				p = p + 16'h0002;
				if (m == 0 && p[15:8] == rx_ring_start_page) p = 16'h4000;
				@(negedge clk);
				chk("dp word", d, wq.pop_front());
				chk("dma addr", p, dma_addr);
			end
			for (int k = 0; k < 3; k++) begin
				rd(OFS_DATA_PORT, v);
				chk("dp read", p ^ 16'h5A3C, v);
				chk("dp rd stb", 16'h0001, 16'(dp_rd_stb));
				p = p + 16'h0002;
			end
			$display("data port test done");
		end
		// Timer period, then silence when off
		tq.delete();
		wr(OFS_TMR_LO, 16'h0003);
		wr(OFS_TMR_HI, 16'h0001);
		wr(OFS_MISC, 16'h0004);
		repeat (600) @(negedge clk);
		wr(OFS_MISC, 16'h0000);
		chk("timer period", 16'h0104, 16'(tq[1] - tq[0]));
		repeat (3) @(negedge clk);
		tq.delete();
		repeat (300) @(negedge clk);
		chk("timer idle", 16'h0000, 16'(tq.size()));
		$display("timer test done");
		// Interrupt and wake pin styles
		foreach (cfg[i]) begin
			c = cfg[i];
			wr(OFS_BUF_CFG, 16'(c));
			for (int q = 1; q >= 0; q--) begin
				irq_req = q[0];
				repeat (3) @(negedge clk);
				chk("irq pin", 16'(pin(q[0], c[5], c[4])), 16'({irq_oe, irq_out}));
			end
			wake_event = 1'b1;
			@(negedge clk);
			wake_event = 1'b0;
			n = 0;
			repeat (40) begin
				@(negedge clk);
				n += int'({wake_oe, wake_out} === pin(1'b1, c[1], c[0]));
			end
			if (c[2]) chk("wake pulse", 16'(WC), 16'(n));
			else begin
				chk("wake level", 16'(pin(1'b1, c[1], c[0])), 16'({wake_oe, wake_out}));
				chk("wake irq", 16'(pin(c[6], c[5], c[4])), 16'({irq_oe, irq_out}));
				wake_clear = 1'b1;
				@(negedge clk);
				wake_clear = 1'b0;
				repeat (3) @(negedge clk);
				chk("wake idle", 16'(pin(1'b0, c[1], c[0])), 16'({wake_oe, wake_out}));
			end
		end
		$display("pin style test done");
		test_done();
	end
endmodule
`default_nettype wire
